// ### sts_snooze_sequencer.sv
// snooze entry decision, oscillator waits and clock release sequencing
`timescale 1ns/1ps
`include "sts_defines.svh"

// What this block does
// R1 - snooze entry only when pre-entry cpu clock is high- or middle-speed oscillator
// R2 - in snooze adc, serial array, remote rx, transfer controller, sequencer, sensing may run
// R3 - stop to snooze on high-speed oscillator, normal start: wait 3.9 to 5.2 us
// R4 - stop to snooze on high-speed oscillator, fast wakeup: wait 0.6 to 0.8 us
// R5 - stop to snooze on middle-speed oscillator: wait 1.3 to 2.5 us
// R6 - snooze to normal, high-speed: 0.3 to 0.4 us plus 10-11 or 4-5 cycles
// R7 - snooze to normal, middle-speed: 0.6 to 1.2 us plus 10-11 or 4-5 cycles
// R8 - middle-speed figures hold only while oscillator trim is at reset value; the block applies this to the stop to snooze wait only, not to the R7 wait
// R9 - clocks gated until oscillator wait ends, then cycle wait before execution
module sts_snooze_sequencer #(
  parameter int CNT_W = 8
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // standby controller requests
  input wire sts_pkg::sts_req_t req,
  input wire logic vectoredIrq,
  // clock configuration
  input wire sts_pkg::sts_src_t cpuClkSrc,
  input wire logic hocoFastWakeup,
  input wire logic midOscTrimAtReset,
  input wire logic [`STS_PERIPH_NUM-1:0] periphSnoozeEn,
  // clock gates and status
  output logic cpuClkEn,
  output logic [`STS_PERIPH_NUM-1:0] periphClkEn,
  output logic snoozeActive,
  output logic entryRefused,
  output logic execResume
);

  // ==========================================
  // wait lengths in cycles
  localparam int HocoNormCyc = `STS_NS_CEIL(`STS_HOCO_NORM_MIN_NS);
  localparam int HocoFastCyc = `STS_NS_CEIL(`STS_HOCO_FAST_MIN_NS);
  localparam int MocoCyc = `STS_NS_CEIL(`STS_MOCO_MIN_NS);
  localparam int MocoUntrimCyc = `STS_NS_FLOOR(`STS_MOCO_MAX_NS);
  localparam int WakeHocoCyc = `STS_NS_CEIL(`STS_WAKE_HOCO_MIN_NS);
  localparam int WakeMocoCyc = `STS_NS_CEIL(`STS_WAKE_MOCO_MIN_NS);
  localparam int CycVect = `STS_CYC_VECTORED;
  localparam int CycPlain = `STS_CYC_PLAIN;

  sts_pkg::sts_state_t state_q, state_d;
  sts_pkg::sts_src_t src_q;
  logic fast_q;
  logic trimOk_q;
  logic vect_q;
  logic [CNT_W-1:0] cnt_q, cnt_d;
  logic entryOk;

  // R1: only the two on-chip oscillators can keep clocking snooze peripherals
  assign entryOk = (src_q == sts_pkg::SRC_HOCO) || (src_q == sts_pkg::SRC_MOCO); // see R1

  // ==========================================
  // source captured at stop entry
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      src_q <= sts_pkg::SRC_OTHER;
      fast_q <= 1'b0;
      trimOk_q <= 1'b1;
    end else if (state_q == sts_pkg::ST_RUN && req.stopEnter) begin
      src_q <= cpuClkSrc;
      fast_q <= hocoFastWakeup;
      trimOk_q <= midOscTrimAtReset;
    end
  end

  // ==========================================
  // interrupt kind latched with the wake request
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      vect_q <= 1'b0;
    end else if ((state_q == sts_pkg::ST_SNOOZE || state_q == sts_pkg::ST_STOP) && req.wakeReq) begin
      vect_q <= vectoredIrq;
    end
  end

  // ==========================================
  // state and wait counter
  always_comb begin
    state_d = state_q;
    cnt_d = (cnt_q != '0) ? cnt_q - 1'b1 : cnt_q;
    case (state_q)
      sts_pkg::ST_RUN: begin
        if (req.stopEnter) begin
          state_d = sts_pkg::ST_STOP;
        end
      end
      sts_pkg::ST_STOP: begin
        if (req.wakeReq) begin
          state_d = sts_pkg::ST_OSC_WAKE;
          cnt_d = (src_q == sts_pkg::SRC_HOCO) ? CNT_W'(WakeHocoCyc - 1)
                                                : CNT_W'(WakeMocoCyc - 1);
        end else if (req.snoozeReq && entryOk) begin // see R1
          state_d = sts_pkg::ST_OSC_SNZ;
          if (src_q == sts_pkg::SRC_HOCO) begin
            cnt_d = fast_q ? CNT_W'(HocoFastCyc - 1) : CNT_W'(HocoNormCyc - 1); // see R3, R4
          end else begin
            // untrimmed oscillator runs unknown: take the longest figure
            cnt_d = trimOk_q ? CNT_W'(MocoCyc - 1) : CNT_W'(MocoUntrimCyc - 1); // see R5, R8
          end
        end
      end
      sts_pkg::ST_OSC_SNZ: begin
        if (cnt_q == '0) begin
          state_d = sts_pkg::ST_SNOOZE;
        end
      end
      sts_pkg::ST_SNOOZE: begin
        if (req.wakeReq) begin
          state_d = sts_pkg::ST_OSC_WAKE;
          cnt_d = (src_q == sts_pkg::SRC_HOCO) ? CNT_W'(WakeHocoCyc - 1) // see R6
                                                : CNT_W'(WakeMocoCyc - 1); // see R7, R8
        end else if (req.snoozeDone) begin
          state_d = sts_pkg::ST_STOP;
        end
      end
      sts_pkg::ST_OSC_WAKE: begin
        if (cnt_q == '0) begin
          state_d = sts_pkg::ST_CYC_WAIT;
          cnt_d = vect_q ? CNT_W'(CycVect - 1) : CNT_W'(CycPlain - 1); // see R6, R7, R9
        end
      end
      sts_pkg::ST_CYC_WAIT: begin
        if (cnt_q == '0) begin
          state_d = sts_pkg::ST_RUN;
        end
      end
      default: begin
        state_d = sts_pkg::ST_RUN;
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      state_q <= sts_pkg::ST_RUN;
      cnt_q <= '0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
    end
  end

  // ==========================================
  // clock gates
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      cpuClkEn <= 1'b1;
      periphClkEn <= '1;
    end else begin
      // R9: clocks return only once the oscillator wait has run out
      cpuClkEn <= (state_d == sts_pkg::ST_RUN) || (state_d == sts_pkg::ST_CYC_WAIT); // see R9
      if (state_d == sts_pkg::ST_SNOOZE) begin
        periphClkEn <= periphSnoozeEn; // see R2
      end else if (state_d == sts_pkg::ST_RUN || state_d == sts_pkg::ST_CYC_WAIT) begin
        periphClkEn <= '1;
      end else begin
        periphClkEn <= '0;
      end
    end
  end

  // ==========================================
  // status pulses and levels
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      snoozeActive <= 1'b0;
      entryRefused <= 1'b0;
      execResume <= 1'b0;
    end else begin
      snoozeActive <= (state_d == sts_pkg::ST_SNOOZE);
      entryRefused <= (state_q == sts_pkg::ST_STOP) && req.snoozeReq && !req.wakeReq
                      && !entryOk; // see R1
      execResume <= (state_q == sts_pkg::ST_CYC_WAIT) && (cnt_q == '0); // see R9
    end
  end

  // ==========================================
  // checks: dwell counts cycles spent in the current state
  logic [CNT_W-1:0] dwell_q;
  always_ff @(posedge ref_clk) begin
    if (reset || state_d != state_q) begin
      dwell_q <= '0;
    end else begin
      dwell_q <= dwell_q + 1'b1;
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);

  chk_entry_source: assert property ( // see R1
    state_q == sts_pkg::ST_OSC_SNZ |-> src_q != sts_pkg::SRC_OTHER)
    else $error("snooze entry from a non-oscillator clock");
  chk_entry_refusal: assert property ( // see R1
    state_q == sts_pkg::ST_STOP && req.snoozeReq && !req.wakeReq && !entryOk
    |=> entryRefused && state_q == sts_pkg::ST_STOP)
    else $error("bad entry not refused");
  chk_snooze_periph: assert property ( // see R2
    snoozeActive |-> (periphClkEn & ~$past(periphSnoozeEn)) == '0)
    else $error("unselected peripheral clocked in snooze");
  chk_hoco_norm: assert property ( // see R3
    state_q == sts_pkg::ST_OSC_SNZ && state_d == sts_pkg::ST_SNOOZE
    && src_q == sts_pkg::SRC_HOCO && !fast_q |-> dwell_q == CNT_W'(HocoNormCyc - 1))
    else $error("normal-start wait length wrong");
  chk_hoco_fast: assert property ( // see R4
    state_q == sts_pkg::ST_OSC_SNZ && state_d == sts_pkg::ST_SNOOZE
    && src_q == sts_pkg::SRC_HOCO && fast_q |-> dwell_q == CNT_W'(HocoFastCyc - 1))
    else $error("fast-start wait length wrong");
  chk_moco_wait: assert property ( // see R5
    state_q == sts_pkg::ST_OSC_SNZ && state_d == sts_pkg::ST_SNOOZE
    && src_q == sts_pkg::SRC_MOCO && trimOk_q |-> dwell_q == CNT_W'(MocoCyc - 1))
    else $error("middle-speed wait length wrong");
  chk_moco_untrim: assert property ( // see R8
    state_q == sts_pkg::ST_OSC_SNZ && state_d == sts_pkg::ST_SNOOZE
    && src_q == sts_pkg::SRC_MOCO && !trimOk_q |-> dwell_q == CNT_W'(MocoUntrimCyc - 1))
    else $error("untrimmed wait length wrong");
  chk_wake_hoco: assert property ( // see R6
    state_q == sts_pkg::ST_OSC_WAKE && state_d == sts_pkg::ST_CYC_WAIT
    && src_q == sts_pkg::SRC_HOCO |-> dwell_q == CNT_W'(WakeHocoCyc - 1))
    else $error("high-speed wake wait wrong");
  chk_wake_moco: assert property ( // see R7
    state_q == sts_pkg::ST_OSC_WAKE && state_d == sts_pkg::ST_CYC_WAIT
    && src_q == sts_pkg::SRC_MOCO |-> dwell_q == CNT_W'(WakeMocoCyc - 1))
    else $error("middle-speed wake wait wrong");
  chk_cycle_wait: assert property ( // see R9
    $rose(execResume) |-> $past(dwell_q) == (vect_q ? CNT_W'(CycVect - 1) : CNT_W'(CycPlain - 1)))
    else $error("cycle wait length wrong");
  chk_gated_wait: assert property ( // see R9
    state_q == sts_pkg::ST_OSC_WAKE |-> !cpuClkEn)
    else $error("cpu clock released during oscillator wait");

endmodule

// ### sts_defines.svh
// timing figures and peripheral slot positions for the snooze transition sequencer
`ifndef STS_DEFINES_SVH
`define STS_DEFINES_SVH

// ==========================================
// clock
`define STS_CLK_PERIOD_NS 100

// ==========================================
// stop to snooze oscillator waits, ns
`define STS_HOCO_NORM_MIN_NS 3900
`define STS_HOCO_FAST_MIN_NS 600
`define STS_MOCO_MIN_NS 1300
`define STS_MOCO_MAX_NS 2500

// ==========================================
// snooze to normal oscillator waits, ns
`define STS_WAKE_HOCO_MIN_NS 300
`define STS_WAKE_MOCO_MIN_NS 600

// ==========================================
// clock-cycle waits after clocks return
`define STS_CYC_VECTORED 10
`define STS_CYC_PLAIN 4

// least times round up, longest round down, never below one cycle
`define STS_NS_CEIL(ns) ((((ns) + `STS_CLK_PERIOD_NS - 1) / `STS_CLK_PERIOD_NS) > 0 ? \
  (((ns) + `STS_CLK_PERIOD_NS - 1) / `STS_CLK_PERIOD_NS) : 1)
`define STS_NS_FLOOR(ns) ((((ns) / `STS_CLK_PERIOD_NS) > 0) ? ((ns) / `STS_CLK_PERIOD_NS) : 1)

// ==========================================
// peripheral slots allowed to run in snooze
`define STS_PERIPH_NUM 6
`define STS_SLOT_ADC 0
`define STS_SLOT_SERIAL_ARRAY_UNIT 1
`define STS_SLOT_REMOTE_CONTROL_RECEIVER 2
`define STS_SLOT_DATA_TRANSFER_CONTROLLER 3
`define STS_SLOT_SNOOZE_SEQUENCER 4
`define STS_SLOT_CAPACITIVE_SENSING_UNIT 5

`endif

// ### sts_pkg.sv
// types shared by the snooze transition sequencer
package sts_pkg;

  // ==========================================
  // sequencer states
  typedef enum logic [2:0] {
    ST_RUN,
    ST_STOP,
    ST_OSC_SNZ,
    ST_SNOOZE,
    ST_OSC_WAKE,
    ST_CYC_WAIT
  } sts_state_t;

  // ==========================================
  // cpu clock source in use
  typedef enum logic [1:0] {
    SRC_HOCO,
    SRC_MOCO,
    SRC_OTHER
  } sts_src_t;

  // ==========================================
  // one-cycle requests from the standby controller
  typedef struct packed {
    logic stopEnter;
    logic snoozeReq;
    logic snoozeDone;
    logic wakeReq;
  } sts_req_t;

endpackage

// ### sts_snooze_sequencer_tb_top.sv
// self-checking bench for the snooze transition sequencer
`timescale 1ns/1ps
`include "sts_defines.svh"

module sts_snooze_sequencer_tb_top;
  // ==========================================
  // signals
  logic ref_clk = 1'b0;
  logic reset = 1'b1;
  sts_pkg::sts_req_t req = '0;
  logic vectoredIrq = 1'b0;
  sts_pkg::sts_src_t cpuClkSrc = sts_pkg::SRC_HOCO;
  logic hocoFastWakeup = 1'b0;
  logic midOscTrimAtReset = 1'b1;
  logic [`STS_PERIPH_NUM-1:0] periphSnoozeEn = '0;
  logic cpuClkEn;
  logic [`STS_PERIPH_NUM-1:0] periphClkEn;
  logic snoozeActive;
  logic entryRefused;
  logic execResume;
  int nErrors = 0;
  int totalChecks = 0;
  logic [31:0] seed = 32'h0000_005d;

  always #50 ref_clk = ~ref_clk;

  sts_snooze_sequencer dut (.ref_clk(ref_clk), .reset(reset), .req(req),
    .vectoredIrq(vectoredIrq), .cpuClkSrc(cpuClkSrc), .hocoFastWakeup(hocoFastWakeup),
    .midOscTrimAtReset(midOscTrimAtReset), .periphSnoozeEn(periphSnoozeEn),
    .cpuClkEn(cpuClkEn), .periphClkEn(periphClkEn), .snoozeActive(snoozeActive),
    .entryRefused(entryRefused), .execResume(execResume));

  // ==========================================
  // model and checks
  function automatic logic [31:0] nextRand();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  // least allowed time, rounded up to whole cycles
  function automatic int cyc(int ns);
    return (ns + 99) / 100;
  endfunction

  function automatic int expSnz(sts_pkg::sts_src_t s, bit fast, bit trim);
    if (s == sts_pkg::SRC_HOCO) return fast ? cyc(600) : cyc(3900);
    return trim ? cyc(1300) : cyc(2500);
  endfunction

  task automatic chkCnt(input int got, input int exp);
    totalChecks++;
    if (got != exp) begin
      nErrors++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chkBits(input logic [8:0] got, input logic [8:0] exp);
    totalChecks++;
    if (got !== exp) begin
      nErrors++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic endOfTest();
    $display("checks=%0d errors=%0d", totalChecks, nErrors);
    if (nErrors == 0 && totalChecks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // ==========================================
  // stimulus
  task automatic pulse(input logic [3:0] r);
    @(negedge ref_clk);
    req = sts_pkg::sts_req_t'(r);
    @(negedge ref_clk);
    req = '0;
  endtask

  // counts cycles until the awaited output; clocks must stay gated meanwhile, except while waiting for execResume
  task automatic waitCnt(input int what, output int k);
    k = 0;
    while (k < 2000) begin
      if (what == 0 && snoozeActive === 1'b1) break;
      if (what == 1 && cpuClkEn === 1'b1) break;
      if (what == 2 && execResume === 1'b1) break;
      if (what < 2) chkBits({2'b00, cpuClkEn, periphClkEn}, 9'h000);
      @(negedge ref_clk);
      k++;
    end
  endtask

  task automatic runSeq(input sts_pkg::sts_src_t s, input bit fast, input bit trim,
                        input bit vect, input bit viaSnz, input bit viaDone);
    int k;
    logic [31:0] rnd;
    cpuClkSrc = s;
    hocoFastWakeup = fast;
    midOscTrimAtReset = trim;
    rnd = nextRand();
    periphSnoozeEn = rnd[`STS_PERIPH_NUM-1:0];
    pulse(4'h8);
    chkBits({2'b00, cpuClkEn, periphClkEn}, 9'h000);
    if (viaSnz) begin
      pulse(4'h4);
      waitCnt(0, k);
      chkCnt(k, expSnz(s, fast, trim));
      chkBits({2'b00, cpuClkEn, periphClkEn}, {3'h0, periphSnoozeEn});
      if (viaDone) begin
        pulse(4'h2);
        chkBits({1'b0, snoozeActive, cpuClkEn, periphClkEn}, 9'h000);
      end
    end
    vectoredIrq = vect;
    pulse(4'h1);
    waitCnt(1, k);
    chkCnt(k, (s == sts_pkg::SRC_HOCO) ? cyc(300) : cyc(600));
    chkBits({2'b00, cpuClkEn, periphClkEn}, 9'h07f);
    waitCnt(2, k);
    chkCnt(k, vect ? 10 : 4);
    @(negedge ref_clk);
    chkBits({7'h00, execResume, cpuClkEn}, 9'h001);
  endtask

  initial begin
    logic [31:0] r;
    repeat (20) @(negedge ref_clk);
    reset = 1'b0;
    chkBits({cpuClkEn, periphClkEn, snoozeActive, entryRefused}, 9'h1fc);
    chkBits({8'h00, execResume}, 9'h000);
    // snooze request in run is ignored
    pulse(4'h4);
    chkBits({6'h00, cpuClkEn, snoozeActive, entryRefused}, 9'h004);
    // both oscillator sources and every wake setting
    for (int i = 0; i < 8; i++) begin
      runSeq(i[2] ? sts_pkg::SRC_MOCO : sts_pkg::SRC_HOCO, i[0], i[1], i[0] ^ i[1], 1'b1, 1'b0);
    end
    // other source: entry refused, then wake from stop
    cpuClkSrc = sts_pkg::SRC_OTHER;
    pulse(4'h8);
    pulse(4'h4);
    chkBits({7'h00, entryRefused, snoozeActive}, 9'h002);
    @(negedge ref_clk);
    chkBits({7'h00, entryRefused, snoozeActive}, 9'h000);
    runSeq(sts_pkg::SRC_OTHER, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0);
    runSeq(sts_pkg::SRC_HOCO, 1'b1, 1'b1, 1'b0, 1'b1, 1'b1);
    // reset in the middle of an oscillator wait must bring clocks straight back
    cpuClkSrc = sts_pkg::SRC_HOCO;
    pulse(4'h8);
    pulse(4'h4);
    chkBits({2'b00, cpuClkEn, periphClkEn}, 9'h000);
    reset = 1'b1;
    repeat (2) @(negedge ref_clk);
    reset = 1'b0;
    chkBits({cpuClkEn, periphClkEn, snoozeActive, entryRefused}, 9'h1fc);
    chkBits({8'h00, execResume}, 9'h000);
    runSeq(sts_pkg::SRC_MOCO, 1'b0, 1'b1, 1'b1, 1'b1, 1'b0);
    // random settings, with and without a snooze leg
    for (int i = 0; i < 10; i++) begin
      r = nextRand();
      runSeq(r[0] ? sts_pkg::SRC_MOCO : sts_pkg::SRC_HOCO, r[1], r[2], r[3], r[4] | r[5], r[6]);
    end
    endOfTest();
  end

  // far beyond the expected run length of about a thousand cycles
  initial begin
    #2000000;
    nErrors++;
    endOfTest();
  end
endmodule
